// file: common/adc_acc_params.svh
`ifndef ADC_ACC_PARAMS_SVH
`define ADC_ACC_PARAMS_SVH

// Register addresses on the special-function bus
`define ACCUMULATE_CONFIG_ADDR 8'hb3
`define BURST_TRACK_TIME_ADDR  8'hb9
`define RESULT_LOW_ADDR        8'hbd
`define RESULT_HIGH_ADDR       8'hbe
`define POWER_CONTROL_ADDR     8'hdf

// Field positions, accumulate_config
`define TWELVE_BIT_ENABLE_BIT  7
`define ACCUMULATE_ENABLE_BIT  6
`define SHIFT_JUSTIFY_FIELD    5:3
`define REPEAT_COUNT_FIELD     2:0

// Field positions, power_control
`define BIAS_SELECT_FIELD      7:6
`define MUX_REF_LP_BIT         5
`define CM_BUFFER_LP_BIT       4
`define POWERUP_DELAY_FIELD    3:0

// Field positions, burst_track_time
`define SINGLE_SAMPLE_BIT      7
`define BURST_TRACK_FIELD      5:0

// Reset values
`define ACCUMULATE_CONFIG_RST  8'h00
`define BURST_TRACK_TIME_RST   8'h1e
`define POWER_CONTROL_RST      8'h0f
`define RESULT_RST             16'h0000

// Timing counts
`define POWERUP_SHIFT          3
`define TRACK_BASE             7'h40
`define DELAYED_TRACK_SAR      3'h4
`define TWELVE_BIT_SUBS        4

`endif

// file: common/adc_acc_pkg.sv
package adc_acc_pkg;

    // Special-function register access, one cycle per strobe
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    // One result from the analog core
    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } core_res_s;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_PWRUP = 6'b000010,
        ST_TMDLY = 6'b000100,
        ST_CONV  = 6'b001000,
        ST_WAIT  = 6'b010000,
        ST_TRACK = 6'b100000
    } seq_state_e;

endpackage

// file: hw/delay_counter.sv
// Loadable down-counter stepped by a tick enable
module delay_counter #(
    parameter int W = 7
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         tick,
    output logic              expired
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // Load wins over a tick in the same cycle
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (tick && count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0);

endmodule

// file: hw/adc_accumulate_ctrl.sv
`include "adc_acc_params.svh"
// Behaviour
// - 12-bit results take four core conversions
// - No burst, no accumulate: latest result replaces
// - No burst, accumulate: results add to pair
// - Shift/justify code formats result reads
// - Burst counts 1,4,8,16,32,64, all accumulated
// - 12-bit burst counts 1,2,4,8,16 results
// - Buffer low power; software lengthens tracking
// - Burst power-up wait is eight times field
// - Delayed track adds four SAR clocks
// - Inter-conversion track is 64 minus field
// - No track delay before first burst conversion
// - Single-sample bit picks one or four samples
// - High byte reads formatted, writes load upper
// - Low byte reads formatted, writes load lower
// - Right shift fills upper bits with zero
// - Delayed track starts conversion four SAR later
module adc_accumulate_ctrl
    import adc_acc_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire sfr_req_s  sfr,
    output logic [7:0]     sfr_rdata,
    input  wire logic      burst_enable,
    input  wire logic      delayed_track_mode,
    input  wire logic      soc,
    input  wire logic      high_freq_oscillator_tick,
    input  wire logic      sar_tick,
    input  wire core_res_s core_res,
    output logic           core_start,
    output logic           core_sample,
    output logic           conv_complete,
    output logic           busy,
    output logic [1:0]     bias_current_select,
    output logic           mux_ref_low_power,
    output logic           cm_buffer_low_power,
    output logic           twelve_bit_mode
);

    logic [7:0]  accumulate_config;
    logic [7:0]  burst_track_time;
    logic [7:0]  power_control;
    logic [15:0] acc;
    logic [7:0]  next_accumulate_config;
    logic [7:0]  next_burst_track_time;
    logic [7:0]  next_power_control;
    logic [15:0] next_acc;

    seq_state_e  state;
    seq_state_e  next_state;
    logic [6:0]  conv_left;
    logic [6:0]  next_conv_left;
    logic [1:0]  sub_idx;
    logic [1:0]  next_sub_idx;
    logic [15:0] sub_sum;
    logic [15:0] next_sub_sum;
    logic        first_res;
    logic        next_first_res;
    logic        next_core_start;
    logic        next_core_sample;
    logic        next_conv_complete;
    logic [7:0]  next_sfr_rdata;

    logic        hf_load;
    logic [6:0]  hf_value;
    logic        hf_done;
    logic        sar_load;
    logic        sar_done;
    logic        result_strobe;
    logic        last_sub;
    logic [15:0] result_value;
    logic [15:0] formatted;
    logic [6:0]  total_conv;

    logic        twelve;
    logic        acc_en;
    logic [2:0]  sj_code;
    logic [2:0]  rpt_code;

    assign twelve   = accumulate_config[`TWELVE_BIT_ENABLE_BIT];
    assign acc_en   = accumulate_config[`ACCUMULATE_ENABLE_BIT];
    assign sj_code  = accumulate_config[`SHIFT_JUSTIFY_FIELD];
    assign rpt_code = accumulate_config[`REPEAT_COUNT_FIELD];

    // Static controls to the analog core come straight from registers
    assign bias_current_select = power_control[`BIAS_SELECT_FIELD];
    assign mux_ref_low_power   = power_control[`MUX_REF_LP_BIT];
    assign cm_buffer_low_power = power_control[`CM_BUFFER_LP_BIT];
    assign twelve_bit_mode     = twelve;

    // Shared counter for power-up and inter-conversion tracking
    delay_counter #(.W(7)) hf_counter (
        .mclk       (mclk),
        .rst        (rst),
        .load       (hf_load),
        .load_value (hf_value),
        .tick       (high_freq_oscillator_tick),
        .expired    (hf_done)
    );

    // Extra SAR clocks of delayed track mode
    delay_counter #(.W(3)) sar_counter (
        .mclk       (mclk),
        .rst        (rst),
        .load       (sar_load),
        .load_value (`DELAYED_TRACK_SAR),
        .tick       (sar_tick),
        .expired    (sar_done)
    );

    // Core conversions per start; 12-bit needs four per result
    always_comb begin
        if (!burst_enable) begin
            total_conv = twelve ? 7'd4 : 7'd1;
        end else begin
            case (rpt_code)
                3'h0:    total_conv = twelve ? 7'd4 : 7'd1;
                3'h1:    total_conv = 7'd4;
                3'h2:    total_conv = 7'd8;
                3'h3:    total_conv = 7'd16;
                3'h4:    total_conv = 7'd32;
                default: total_conv = 7'd64; // Reserved codes clamp
            endcase
        end
    end

    // Partial sum of the sub-conversions of one result
    assign last_sub      = !twelve || sub_idx == 2'd3;
    assign result_value  = (sub_idx == 2'd0 ? 16'h0000 : sub_sum)
                         + {4'h0, core_res.data};
    assign result_strobe = state == ST_WAIT && core_res.valid && last_sub;

    // Sequencer: power-up, delayed track, convert, inter-track
    always_comb begin
        next_state         = state;
        next_conv_left     = conv_left;
        next_sub_idx       = sub_idx;
        next_sub_sum       = sub_sum;
        next_first_res     = first_res;
        next_core_start    = 1'b0;
        next_core_sample   = core_sample;
        next_conv_complete = 1'b0;
        hf_load            = 1'b0;
        hf_value           = 7'h00;
        sar_load           = 1'b0;
        case (state)
            ST_IDLE: begin
                if (soc) begin
                    next_conv_left = total_conv;
                    next_sub_idx   = 2'd0;
                    next_first_res = 1'b1;
                    if (burst_enable) begin
                        hf_load    = 1'b1;
                        hf_value   = {power_control[`POWERUP_DELAY_FIELD],
                                      3'b000};
                        next_state = ST_PWRUP;
                    end else if (delayed_track_mode) begin
                        sar_load   = 1'b1;
                        next_state = ST_TMDLY;
                    end else begin
                        next_state = ST_CONV;
                    end
                end
            end
            ST_PWRUP, ST_TRACK: begin
                if (hf_done) begin
                    if (delayed_track_mode) begin
                        sar_load   = 1'b1;
                        next_state = ST_TMDLY;
                    end else begin
                        next_state = ST_CONV;
                    end
                end
            end
            ST_TMDLY: begin
                if (sar_done) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                next_core_start  = 1'b1;
                // One sample per 12-bit result when asked for
                next_core_sample = !(twelve && sub_idx != 2'd0 &&
                    burst_track_time[`SINGLE_SAMPLE_BIT]);
                next_state       = ST_WAIT;
            end
            ST_WAIT: begin
                if (core_res.valid) begin
                    next_sub_sum   = result_value;
                    next_sub_idx   = last_sub ? 2'd0 : sub_idx + 2'd1;
                    next_conv_left = conv_left - 7'd1;
                    if (last_sub) begin
                        next_first_res = 1'b0;
                    end
                    if (conv_left == 7'd1) begin
                        next_conv_complete = 1'b1;
                        next_state         = ST_IDLE;
                    end else if (burst_enable) begin
                        // Track delay only between conversions
                        hf_load    = 1'b1;
                        hf_value   = `TRACK_BASE -
                            {1'b0, burst_track_time[`BURST_TRACK_FIELD]};
                        next_state = ST_TRACK;
                    end else begin
                        next_state = ST_CONV;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state         <= ST_IDLE;
            conv_left     <= 7'h00;
            sub_idx       <= 2'd0;
            sub_sum       <= 16'h0000;
            first_res     <= 1'b0;
            core_start    <= 1'b0;
            core_sample   <= 1'b0;
            conv_complete <= 1'b0;
            busy          <= 1'b0;
        end else begin
            state         <= next_state;
            conv_left     <= next_conv_left;
            sub_idx       <= next_sub_idx;
            sub_sum       <= next_sub_sum;
            first_res     <= next_first_res;
            core_start    <= next_core_start;
            core_sample   <= next_core_sample;
            conv_complete <= next_conv_complete;
            busy          <= next_state != ST_IDLE;
        end
    end

    // Registers and accumulator; a software write beats a new result in the byte it writes
    always_comb begin
        next_accumulate_config = accumulate_config;
        next_burst_track_time  = burst_track_time;
        next_power_control     = power_control;
        next_acc               = acc;
        if (result_strobe) begin
            if (acc_en || (burst_enable && !first_res)) begin
                next_acc = acc + result_value;
            end else begin
                next_acc = result_value;
            end
        end
        if (sfr.wr) begin
            case (sfr.addr)
                `ACCUMULATE_CONFIG_ADDR: next_accumulate_config = sfr.wdata;
                `BURST_TRACK_TIME_ADDR:  next_burst_track_time  = sfr.wdata;
                `POWER_CONTROL_ADDR:     next_power_control     = sfr.wdata;
                `RESULT_HIGH_ADDR: next_acc[15:8] = sfr.wdata;
                `RESULT_LOW_ADDR:  next_acc[7:0]  = sfr.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            accumulate_config <= `ACCUMULATE_CONFIG_RST;
            burst_track_time  <= `BURST_TRACK_TIME_RST;
            power_control     <= `POWER_CONTROL_RST;
            acc               <= `RESULT_RST;
        end else begin
            accumulate_config <= next_accumulate_config;
            burst_track_time  <= next_burst_track_time;
            power_control     <= next_power_control;
            acc               <= next_acc;
        end
    end

    // Read formatting; reserved codes read the raw sum
    always_comb begin
        case (sj_code)
            3'h0:    formatted = acc;
            3'h1:    formatted = acc >> 1;
            3'h2:    formatted = acc >> 2;
            3'h3:    formatted = acc >> 3;
            3'h4:    formatted = twelve ? acc << 4 : acc << 6;
            default: formatted = acc;
        endcase
    end

    // Read data is registered, so it answers one cycle after the strobe
    always_comb begin
        next_sfr_rdata = sfr_rdata;
        if (sfr.rd) begin
            case (sfr.addr)
                `ACCUMULATE_CONFIG_ADDR: next_sfr_rdata = accumulate_config;
                `BURST_TRACK_TIME_ADDR:  next_sfr_rdata = burst_track_time;
                `POWER_CONTROL_ADDR:     next_sfr_rdata = power_control;
                `RESULT_HIGH_ADDR: next_sfr_rdata = formatted[15:8];
                `RESULT_LOW_ADDR:  next_sfr_rdata = formatted[7:0];
                default:           next_sfr_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // Helper counts of delay ticks, read only by the checks below
    logic [6:0] hf_seen;
    logic [2:0] sar_seen;
    always_ff @(posedge mclk) begin
        if (rst || hf_load) begin
            hf_seen <= 7'h00;
        end else if (high_freq_oscillator_tick && !hf_done) begin
            hf_seen <= hf_seen + 7'd1;
        end
        if (rst || sar_load) begin
            sar_seen <= 3'h0;
        end else if (sar_tick && !sar_done) begin
            sar_seen <= sar_seen + 3'd1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    powerup_wait_a: assert property (
        state == ST_PWRUP && hf_done && !sfr.wr |->
        hf_seen == {power_control[`POWERUP_DELAY_FIELD], 3'b000})
        else $error("power-up wait length wrong");
    track_wait_a: assert property (
        state == ST_TRACK && hf_done && !sfr.wr |->
        hf_seen == `TRACK_BASE -
            {1'b0, burst_track_time[`BURST_TRACK_FIELD]})
        else $error("burst track delay length wrong");
    delayed_track_a: assert property (
        state == ST_TMDLY && sar_done |-> sar_seen == 3'd4 ##2 core_start)
        else $error("delayed track not four SAR clocks");
    no_first_track_a: assert property (
        state == ST_PWRUP && hf_done |=> state != ST_TRACK)
        else $error("track delay before first conversion");
    replace_result_a: assert property (
        result_strobe && !burst_enable && !acc_en && !sfr.wr |=>
        acc == $past(result_value))
        else $error("latest result not stored");
    running_sum_a: assert property (
        result_strobe && !burst_enable && acc_en && !sfr.wr |=>
        acc == $past(acc) + $past(result_value))
        else $error("result not accumulated");
    complete_last_a: assert property (
        $rose(conv_complete) |-> $past(conv_left) == 7'd1 &&
        $past(state) == ST_WAIT && state == ST_IDLE)
        else $error("complete raised before last conversion");
    burst_reload_a: assert property (
        state == ST_IDLE && soc |=> conv_left == $past(total_conv))
        else $error("conversion counter not reloaded");
    shift_zero_a: assert property (
        sfr.rd && sfr.addr == `RESULT_HIGH_ADDR && sj_code == 3'h3 |=>
        sfr_rdata[7:5] == 3'b000)
        else $error("shifted read has non-zero top bits");
    twelve_quarter_a: assert property (
        result_strobe && twelve |-> conv_left[1:0] == 2'b01)
        else $error("12-bit result not from four conversions");
    single_sample_a: assert property (
        core_start && twelve && sub_idx != 2'd0 &&
        burst_track_time[`SINGLE_SAMPLE_BIT] |-> !core_sample)
        else $error("re-sampled in single-sample mode");

    burst_done_c: cover property (
        burst_enable && conv_complete && rpt_code == 3'h5);
    twelve_done_c: cover property (twelve && conv_complete);
    delayed_conv_c: cover property (state == ST_TMDLY ##[1:200] core_start);

endmodule

// file: sim/sar_core_model.sv
// Behavioural SAR core: answers each start after a short or long latency
module sar_core_model
    import adc_acc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        core_start,
    input  wire logic        slow,
    input  wire logic [11:0] next_data,
    output core_res_s        core_res
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] wait_cnt;
    logic       pending;

    // Stale data is inverted every cycle so it never looks valid by luck
    always @(posedge mclk) begin
        if (rst) begin
            pending  <= 1'b0;
            wait_cnt <= 4'h0;
            core_res <= '0;
        end else begin
            core_res.valid <= 1'b0;
            core_res.data  <= ~core_res.data;
            if (core_start) begin
                pending  <= 1'b1;
                wait_cnt <= slow ? 4'h9 : 4'h0;
            end else if (pending) begin
                if (wait_cnt == 4'h0) begin
                    pending        <= 1'b0;
                    core_res.valid <= 1'b1;
                    core_res.data  <= next_data;
                end else begin
                    wait_cnt <= wait_cnt - 4'h1;
                end
            end
        end
    end
endmodule

// file: sim/testbench.sv
`include "adc_acc_params.svh"
module testbench
    import adc_acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk, rst, burst_enable, delayed_track_mode, soc, slow;
    logic high_freq_oscillator_tick, sar_tick, core_start, core_sample, conv_complete;
    logic busy, mux_ref_low_power, cm_buffer_low_power, twelve_bit_mode;
    logic [1:0]  bias_current_select;
    logic [7:0]  sfr_rdata, rv, pv, tv;
    logic [11:0] next_data, last_data;
    logic [15:0] sum_data, tot, res;
    sfr_req_s    sfr;
    core_res_s   core_res;
    int seed = 82;
    int err_count = 0;
    int samples_checked = 0;
    int n_start, n_sample, hc, sc, tph, n;
    int gh[64];
    int gs[64];
    logic [7:0] ra[6] = '{8'hb3, 8'hb9, 8'hdf, 8'hbe, 8'hbd, 8'h10};
    logic [7:0] rx[6] = '{8'h00, 8'h1e, 8'h0f, 8'h00, 8'h00, 8'h00};

    adc_accumulate_ctrl dut (.mclk(mclk), .rst(rst), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .burst_enable(burst_enable),
        .delayed_track_mode(delayed_track_mode), .soc(soc),
        .high_freq_oscillator_tick(high_freq_oscillator_tick), .sar_tick(sar_tick), .core_res(core_res),
        .core_start(core_start), .core_sample(core_sample),
        .conv_complete(conv_complete), .busy(busy),
        .bias_current_select(bias_current_select),
        .mux_ref_low_power(mux_ref_low_power),
        .cm_buffer_low_power(cm_buffer_low_power),
        .twelve_bit_mode(twelve_bit_mode));
    sar_core_model core (.mclk(mclk), .rst(rst), .core_start(core_start),
        .slow(slow), .next_data(next_data), .core_res(core_res));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Oscillator every 2 cycles, SAR clock every 3, fresh core data
    always @(posedge mclk) begin
        tph        <= (tph == 5) ? 0 : tph + 1;
        high_freq_oscillator_tick <= tph[0];
        sar_tick   <= (tph % 3) == 2;
        next_data  <= 12'($random(seed));
    end

    // Monitor: starts, samples, core data sum, tick gaps before each start
    always @(posedge mclk) begin
        if (soc) begin
            n_start  <= 0;
            n_sample <= 0;
            sum_data <= 16'h0000;
            hc       <= 0;
            sc       <= 0;
        end else begin
            if (core_res.valid) begin
                sum_data  <= sum_data + 16'(core_res.data);
                last_data <= core_res.data;
                hc        <= 0;
                sc        <= 0;
            end else begin
                hc <= hc + int'(high_freq_oscillator_tick);
                sc <= sc + int'(sar_tick);
            end
            if (core_start === 1'b1 && n_start < 64) begin
                gh[n_start] <= hc;
                gs[n_start] <= sc;
                n_start     <= n_start + 1;
                n_sample    <= n_sample + int'(core_sample);
            end
        end
    end

    function automatic int core_count(input logic [2:0] c, input logic tw);
        if (c > 3'h5) return 64;
        if (c == 3'h0) return tw ? 4 : 1;
        return 2 << c;
    endfunction

    function automatic logic [15:0] fmt(input logic [15:0] a,
                                        input logic [2:0] c,
                                        input logic tw);
        if (c < 3'h4) return a >> c;
        if (c == 3'h4) return tw ? a << 4 : a << 6;
        return a;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    task automatic in_range(input int v, input int lo, input int hi,
                            input string msg);
        check(16'(v >= lo && v <= hi), 16'h1, msg);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr.wr    <= 1'b1;
        sfr.addr  <= a;
        sfr.wdata <= d;
        @(posedge mclk);
        sfr.wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        sfr.rd   <= 1'b1;
        sfr.addr <= a;
        @(posedge mclk);
        sfr.rd <= 1'b0;
        @(posedge mclk);
        #1 d = sfr_rdata;
    endtask

    task automatic read_result(output logic [15:0] r);
        reg_read(8'hbe, r[15:8]);
        reg_read(8'hbd, r[7:0]);
    endtask

    // One start, bounded wait for the completion pulse
    task automatic run();
        int i;
        @(posedge mclk);
        soc  <= 1'b1;
        slow <= 1'($random(seed));
        @(posedge mclk);
        soc <= 1'b0;
        @(posedge mclk);
        check(16'(busy), 16'h1, "busy after start");
        for (i = 0; i < 20000 && conv_complete !== 1'b1; i++) @(posedge mclk);
        check(16'(i < 20000), 16'h1, "completion");
        check(16'(busy), 16'h0, "idle at completion");
        @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #4000000;
        err_count++;
        complete_run();
    end

    initial begin
        {rst, burst_enable, delayed_track_mode, soc, slow} = 5'b10000;
        {high_freq_oscillator_tick, sar_tick, tph, next_data} = '0;
        sfr = '0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        // Reset values, unmapped address reads zero
        for (int i = 0; i < 6; i++) begin
            reg_read(ra[i], rv);
            check(rv, rx[i], "reset value");
        end
        check(bias_current_select, 2'b00, "bias reset");
        pv = 8'($random(seed)) | 8'h40;
        reg_write(8'hdf, pv);
        reg_read(8'hdf, rv);
        check(rv, pv, "power readback");
        check({bias_current_select, mux_ref_low_power, cm_buffer_low_power},
              pv[7:4], "power outputs");
        $display("test registers done");
        // Latest result replaces, then running sum with software clear
        reg_write(8'hb3, 8'h00);
        repeat (2) begin
            run();
            read_result(res);
            check(res, 16'(last_data), "replace");
        end
        reg_write(8'hbe, 8'h00);
        reg_write(8'hbd, 8'h00);
        reg_write(8'hb3, 8'h40);
        tot = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                reg_write(8'hbe, 8'hff);
                reg_write(8'hbd, 8'hf0);
                tot = 16'hfff0;
            end
            run();
            tot = tot + sum_data;
            read_result(res);
            check(res, tot, "running sum");
        end
        $display("test accumulate done");
        // 12-bit single conversion: four subs, one or four samples
        for (int ss = 0; ss < 2; ss++) begin
            reg_write(8'hb9, {1'(ss), 7'h1e});
            reg_write(8'hb3, 8'h80);
            run();
            check(16'(twelve_bit_mode), 16'h1, "12-bit output");
            check(16'(n_start), 16'h4, "12-bit subs");
            check(16'(n_sample), ss ? 16'h1 : 16'h4, "samples");
            read_result(res);
            check(res, sum_data, "12-bit sum");
        end
        $display("test single done");
        // Every justify code in both resolutions
        reg_write(8'hbe, 8'($random(seed)));
        reg_write(8'hbd, 8'($random(seed)));
        reg_write(8'hb3, 8'h00);
        read_result(tot);
        for (int c = 0; c < 16; c++) begin
            reg_write(8'hb3, {1'(c >> 3), 1'b0, 3'(c), 3'h0});
            read_result(res);
            check(res, fmt(tot, 3'(c), 1'(c >> 3)), "justify");
        end
        $display("test justify done");
        // Every repeat code, counts and sums; tracking gaps in 8-bit mode only
        @(posedge mclk);
        burst_enable <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            if (c == 8) continue;
            pv = (c == 1) ? 8'h40 : {4'h4, 4'($random(seed))};
            tv = (c == 2) ? 8'h3f : {2'b00, 1'b1, 5'($random(seed))};
            reg_write(8'hdf, pv);
            reg_write(8'hb9, tv);
            reg_write(8'hb3, {1'(c >> 3), 4'h0, 3'(c)});
            run();
            n = core_count(3'(c), 1'(c >> 3));
            check(16'(n_start), 16'(n), "burst count");
            read_result(res);
            check(res, sum_data, "burst sum");
            if (c < 8) begin
                in_range(gh[0], 8 * pv[3:0], 8 * pv[3:0] + 2, "pwrup");
                for (int i = 1; i < n; i++)
                    in_range(gh[i], 64 - tv[5:0], 66 - tv[5:0], "trk");
            end
        end
        $display("test burst done");
        // Delayed track, burst and single, shortest oscillator waits
        @(posedge mclk);
        delayed_track_mode <= 1'b1;
        reg_write(8'hdf, 8'h40);
        reg_write(8'hb9, 8'h3f);
        for (int b = 1; b >= 0; b--) begin
            burst_enable <= 1'(b);
            reg_write(8'hb3, {7'h00, 1'(b)});
            run();
            for (int i = 0; i < n_start; i++)
                in_range(gs[i], 4, 6, "delayed");
        end
        $display("test delayed done");
        complete_run();
    end
endmodule
